// ### include/prk_pkg.sv
// Package of constants and types for the peripheral register lock block
package prk_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int GROUP_W  = 8;
  localparam int GIDX_W   = 3;
  localparam int PERIPH_W = 16;
  localparam int SEL_W    = 4;
  localparam int KEY_W    = 8;

  // ****************************************************************
  // Key sequence values, arbitrary choices
  // ****************************************************************
  localparam logic [KEY_W-1:0] KEY_FIRST  = 8'hA5;
  localparam logic [KEY_W-1:0] KEY_SECOND = 8'hF1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [GROUP_W-1:0]  LOCK_RST = 8'h00;
  localparam logic [PERIPH_W-1:0] HALT_RST = 16'h0000;

  // Peripheral select bits above this shift give the group index
  localparam int GROUP_SHIFT = 1;

  // ****************************************************************
  // Key sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_GOT_FIRST,
    KEY_OPEN
  } prk_key_state_t;

endpackage

// ### include/prk_key_if.sv
// Interface between the lock top and its key sequencer
`timescale 1ns/100ps
interface prk_key_if;
  logic                     wrEn;
  logic [prk_pkg::KEY_W-1:0] wrData;
  logic                     unlocked;

  modport seq (
    input  wrEn,
    input  wrData,
    output unlocked
  );

  modport owner (
    output wrEn,
    output wrData,
    input  unlocked
  );
endinterface

// ### design/prk_key_seq.sv
// Key sequencer that opens and closes access to the group lock bits
`timescale 1ns/100ps
module prk_key_seq (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Key path
  prk_key_if.seq   key
);

  prk_pkg::prk_key_state_t state_ff;
  prk_pkg::prk_key_state_t nxt_state;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    if (key.wrEn) begin
      unique case (state_ff)
        prk_pkg::KEY_LOCKED: begin
          if (key.wrData == prk_pkg::KEY_FIRST) begin
            nxt_state = prk_pkg::KEY_GOT_FIRST;
          end
        end
        prk_pkg::KEY_GOT_FIRST: begin
          if (key.wrData == prk_pkg::KEY_SECOND) begin
            nxt_state = prk_pkg::KEY_OPEN;
          end else if (key.wrData == prk_pkg::KEY_FIRST) begin
            nxt_state = prk_pkg::KEY_GOT_FIRST;
          end else begin
            nxt_state = prk_pkg::KEY_LOCKED;
          end
        end
        prk_pkg::KEY_OPEN: begin
          nxt_state = prk_pkg::KEY_LOCKED;
        end
        default: begin
          nxt_state = prk_pkg::KEY_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= prk_pkg::KEY_LOCKED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign key.unlocked = (state_ff == prk_pkg::KEY_OPEN);

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence keyPairSeq;
    key.wrEn && key.wrData == prk_pkg::KEY_FIRST && !key.unlocked
    ##1 key.wrEn && key.wrData == prk_pkg::KEY_SECOND;
  endsequence

  key_unlock_a: assert property (@(posedge clock) disable iff (!rst_n)
    keyPairSeq |=> key.unlocked)
    else $error("key pair did not unlock");

  key_relock_a: assert property (@(posedge clock) disable iff (!rst_n)
    key.unlocked && key.wrEn |=> !key.unlocked)
    else $error("key write while open did not relock");

  key_wrong_a: assert property (@(posedge clock) disable iff (!rst_n)
    !key.unlocked && key.wrEn && key.wrData != prk_pkg::KEY_FIRST
    && key.wrData != prk_pkg::KEY_SECOND |=> !key.unlocked [*2])
    else $error("wrong key opened the lock bits");

endmodule // prk_key_seq

// ### design/prk_lock_top.sv
// Peripheral register lock top: group lock bits, write filter, debug freeze
`timescale 1ns/100ps
module prk_lock_top (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // Key register port
  input  wire logic                          keyWrEn,
  input  wire logic [prk_pkg::KEY_W-1:0]     keyWrData,
  input  wire logic                          keyRdEn,
  output logic                               keyRdUnlocked,
  // Lock bit register port
  input  wire logic                          lockWrEn,
  input  wire logic [prk_pkg::GROUP_W-1:0]   lockWrData,
  output logic [prk_pkg::GROUP_W-1:0]        peripheral_group_lock_bits,
  output logic                               lockWrRefused,
  // Peripheral access filter
  input  wire logic                          periphWrReq,
  input  wire logic                          periphRdReq,
  input  wire logic [prk_pkg::SEL_W-1:0]     periphSel,
  output logic                               periphWrAllow,
  output logic                               periphRdAllow,
  output logic                               periphWrDropped,
  // Debug halt
  input  wire logic                          cfgWrEn,
  input  wire logic [prk_pkg::PERIPH_W-1:0]  cfgWrData,
  input  wire logic                          coreHalted,
  output logic [prk_pkg::PERIPH_W-1:0]       haltCfg,
  output logic [prk_pkg::PERIPH_W-1:0]       periphFreeze
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [prk_pkg::GIDX_W-1:0] groupOf(
    input logic [prk_pkg::SEL_W-1:0] sel
  );
    groupOf = prk_pkg::GIDX_W'(sel >> prk_pkg::GROUP_SHIFT);
  endfunction

  function automatic logic isLocked(
    input logic [prk_pkg::GROUP_W-1:0] bits,
    input logic [prk_pkg::SEL_W-1:0]   sel
  );
    isLocked = bits[groupOf(sel)];
  endfunction

  // ****************************************************************
  // Key sequencer
  // ****************************************************************
  prk_key_if keyBus ();

  assign keyBus.wrEn   = keyWrEn;
  assign keyBus.wrData = keyWrData;

  prk_key_seq u_key_seq (
    .clock (clock),
    .rst_n (rst_n),
    .key   (keyBus.seq)
  );

  // ****************************************************************
  // Lock bits
  // ****************************************************************
  logic [prk_pkg::GROUP_W-1:0] lockBits_ff;
  logic [prk_pkg::GROUP_W-1:0] nxt_lockBits;
  logic                        lockRefused_ff;
  logic                        nxt_lockRefused;
  logic                        keyStatus_ff;
  logic                        nxt_keyStatus;
  logic                        lockOpen;

  // A key write in the same cycle closes access before the lock write lands
  assign lockOpen = keyBus.unlocked && !keyWrEn;

  always_comb begin
    nxt_lockBits    = lockBits_ff;
    nxt_lockRefused = 1'b0;
    nxt_keyStatus   = keyStatus_ff;
    if (lockWrEn) begin
      if (lockOpen) begin
        nxt_lockBits = lockWrData;
      end else begin
        nxt_lockRefused = 1'b1;
      end
    end
    if (keyRdEn) begin
      nxt_keyStatus = keyBus.unlocked;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lockBits_ff    <= prk_pkg::LOCK_RST;
      lockRefused_ff <= 1'b0;
      keyStatus_ff   <= 1'b0;
    end else begin
      lockBits_ff    <= nxt_lockBits;
      lockRefused_ff <= nxt_lockRefused;
      keyStatus_ff   <= nxt_keyStatus;
    end
  end

  assign peripheral_group_lock_bits = lockBits_ff;
  assign lockWrRefused              = lockRefused_ff;
  assign keyRdUnlocked              = keyStatus_ff;

  // ****************************************************************
  // Peripheral access filter
  // ****************************************************************
  logic periphDrop_ff;
  logic nxt_periphDrop;

  assign periphWrAllow = periphWrReq && !isLocked(lockBits_ff, periphSel);
  assign periphRdAllow = periphRdReq;

  always_comb begin
    nxt_periphDrop = periphWrReq && isLocked(lockBits_ff, periphSel);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      periphDrop_ff <= 1'b0;
    end else begin
      periphDrop_ff <= nxt_periphDrop;
    end
  end

  assign periphWrDropped = periphDrop_ff;

  // ****************************************************************
  // Debug halt freeze
  // ****************************************************************
  logic [prk_pkg::PERIPH_W-1:0] haltCfg_ff;
  logic [prk_pkg::PERIPH_W-1:0] nxt_haltCfg;
  logic [prk_pkg::PERIPH_W-1:0] freeze_ff;
  logic [prk_pkg::PERIPH_W-1:0] nxt_freeze;

  always_comb begin
    nxt_haltCfg = haltCfg_ff;
    if (cfgWrEn) begin
      nxt_haltCfg = cfgWrData;
    end
    nxt_freeze = coreHalted ? haltCfg_ff : '0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      haltCfg_ff <= prk_pkg::HALT_RST;
      freeze_ff  <= '0;
    end else begin
      haltCfg_ff <= nxt_haltCfg;
      freeze_ff  <= nxt_freeze;
    end
  end

  assign haltCfg      = haltCfg_ff;
  assign periphFreeze = freeze_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence closedWriteSeq;
    lockWrEn && !lockOpen;
  endsequence

  lock_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    closedWriteSeq |=> $stable(lockBits_ff) && lockWrRefused)
    else $error("lock bits changed while key closed");

  lock_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    lockWrEn && keyBus.unlocked && !keyWrEn |=> lockBits_ff == $past(lockWrData))
    else $error("open lock write not taken");

  relock_same_a: assert property (@(posedge clock) disable iff (!rst_n)
    lockWrEn && keyWrEn |=> $stable(lockBits_ff))
    else $error("lock write taken with key write");

  status_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    keyRdEn && !keyWrEn |=> keyRdUnlocked == keyBus.unlocked
    && keyBus.unlocked == $past(keyBus.unlocked))
    else $error("key status read wrong or disturbed state");

  wr_block_a: assert property (@(posedge clock) disable iff (!rst_n)
    periphWrReq && lockBits_ff[groupOf(periphSel)] |-> !periphWrAllow
    ##1 periphWrDropped)
    else $error("write to locked group not dropped");

  wr_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
    periphWrReq && !lockBits_ff[groupOf(periphSel)] |-> periphWrAllow
    ##1 !periphWrDropped)
    else $error("write to open group blocked");

  rd_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
    periphRdReq && lockBits_ff[groupOf(periphSel)] |-> periphRdAllow)
    else $error("read of locked peripheral refused");

  freeze_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
    coreHalted [*2] |=> periphFreeze == $past(haltCfg_ff))
    else $error("freeze does not follow halt option");

  reset_state_a: assert property (@(posedge clock)
    !rst_n |=> lockBits_ff == prk_pkg::LOCK_RST && !keyBus.unlocked)
    else $error("reset did not clear lock state");

endmodule // prk_lock_top

// ### dv/test_prk_lock_top.sv
// Self-checking bench for the peripheral register lock top
`timescale 1ns/100ps
module test_prk_lock_top;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic                          clock;
  logic                          rst_n;
  logic                          keyWrEn;
  logic [prk_pkg::KEY_W-1:0]     keyWrData;
  logic                          keyRdEn;
  logic                          keyRdUnlocked;
  logic                          lockWrEn;
  logic [prk_pkg::GROUP_W-1:0]   lockWrData;
  logic [prk_pkg::GROUP_W-1:0]   peripheral_group_lock_bits;
  logic                          lockWrRefused;
  logic                          periphWrReq;
  logic                          periphRdReq;
  logic [prk_pkg::SEL_W-1:0]     periphSel;
  logic                          periphWrAllow;
  logic                          periphRdAllow;
  logic                          periphWrDropped;
  logic                          cfgWrEn;
  logic [prk_pkg::PERIPH_W-1:0]  cfgWrData;
  logic                          coreHalted;
  logic [prk_pkg::PERIPH_W-1:0]  haltCfg;
  logic [prk_pkg::PERIPH_W-1:0]  periphFreeze;
  logic [prk_pkg::GROUP_W-1:0]   lockModel;
  logic                          wrExp;
  int                            err_count;
  int                            n_tests;

  prk_lock_top u_prk_lock_top (
    .clock, .rst_n, .keyWrEn, .keyWrData, .keyRdEn, .keyRdUnlocked,
    .lockWrEn, .lockWrData, .peripheral_group_lock_bits, .lockWrRefused,
    .periphWrReq, .periphRdReq, .periphSel, .periphWrAllow, .periphRdAllow,
    .periphWrDropped, .cfgWrEn, .cfgWrData, .coreHalted, .haltCfg, .periphFreeze
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic step;
    @(posedge clock);
    #1;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic chk_vec(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic grp_locked(input logic [7:0] bits, input logic [3:0] sel);
    return bits[sel >> prk_pkg::GROUP_SHIFT];
  endfunction

  task automatic key_wr(input logic [7:0] d);
    keyWrEn = 1'b1;
    keyWrData = d;
    step;
    keyWrEn = 1'b0;
    step;
  endtask

  // Back-to-back key pair, strobe held high across both writes
  task automatic open_key;
    keyWrEn = 1'b1;
    keyWrData = prk_pkg::KEY_FIRST;
    step;
    keyWrData = prk_pkg::KEY_SECOND;
    step;
    keyWrEn = 1'b0;
    step;
  endtask

  task automatic rd_key(input logic e);
    keyRdEn = 1'b1;
    step;
    keyRdEn = 1'b0;
    chk_bit("keyRdUnlocked", e, keyRdUnlocked);
    step;
  endtask

  task automatic lock_wr(input logic [7:0] d, input logic acc);
    lockWrEn = 1'b1;
    lockWrData = d;
    step;
    lockWrEn = 1'b0;
    if (acc) lockModel = d;
    chk_bit("lockWrRefused", !acc, lockWrRefused);
    chk_vec("lock bits", {8'h00, lockModel}, {8'h00, peripheral_group_lock_bits});
    step;
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clock);
    err_count++;
    print_verdict;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_n, keyWrEn, keyRdEn, lockWrEn, periphWrReq, periphRdReq, cfgWrEn, coreHalted} = 8'h00;
    keyWrData = 8'h00;
    lockWrData = 8'h00;
    periphSel = 4'h0;
    cfgWrData = 16'h0000;
    lockModel = 8'h00;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'hCC2B));
    repeat (6) step;
    rst_n = 1'b1;
    chk_vec("lock bits", 16'h0000, {8'h00, peripheral_group_lock_bits});
    chk_vec("haltCfg", 16'h0000, haltCfg);
    rd_key(1'b0);
    lock_wr(8'h3C, 1'b0);
    key_wr(prk_pkg::KEY_FIRST);
    key_wr(8'h11);
    key_wr(prk_pkg::KEY_SECOND);
    rd_key(1'b0);
    key_wr(prk_pkg::KEY_FIRST);
    lock_wr(8'hC3, 1'b0);
    open_key;
    rd_key(1'b1);
    rd_key(1'b1);
    lock_wr(8'hFF, 1'b1);
    lock_wr(8'h00, 1'b1);
    lock_wr(8'($urandom), 1'b1);
    keyWrEn = 1'b1;
    keyWrData = 8'h00;
    lockWrEn = 1'b1;
    lockWrData = 8'h55;
    step;
    keyWrEn = 1'b0;
    lockWrEn = 1'b0;
    chk_bit("lockWrRefused", 1'b1, lockWrRefused);
    step;
    rd_key(1'b0);
    lock_wr(8'hAA, 1'b0);
    open_key;
    key_wr(prk_pkg::KEY_FIRST);
    rd_key(1'b0);
    for (int i = 0; i < 48; i++) begin
      if (i % 16 == 0) begin
        open_key;
        lock_wr((i == 0) ? 8'hFF : 8'($urandom), 1'b1);
        key_wr(8'h00);
      end
      periphWrReq = 1'($urandom);
      periphRdReq = 1'($urandom);
      periphSel = 4'($urandom);
      @(negedge clock);
      wrExp = periphWrReq & grp_locked(lockModel, periphSel);
      chk_bit("periphWrAllow", periphWrReq & !wrExp, periphWrAllow);
      chk_bit("periphRdAllow", periphRdReq, periphRdAllow);
      step;
      chk_bit("periphWrDropped", wrExp, periphWrDropped);
    end
    periphWrReq = 1'b0;
    periphRdReq = 1'b0;
    for (int i = 0; i < 12; i++) begin
      cfgWrEn = 1'b1;
      cfgWrData = (i == 0) ? 16'hFFFF : 16'($urandom);
      coreHalted = (i < 2) ? i[0] : 1'($urandom);
      step;
      cfgWrEn = 1'b0;
      chk_vec("haltCfg", cfgWrData, haltCfg);
      step;
      chk_vec("periphFreeze", coreHalted ? cfgWrData : 16'h0000, periphFreeze);
    end
    open_key;
    lock_wr(8'h5A, 1'b1);
    rst_n = 1'b0;
    step;
    step;
    rst_n = 1'b1;
    lockModel = 8'h00;
    chk_vec("lock bits", 16'h0000, {8'h00, peripheral_group_lock_bits});
    chk_vec("haltCfg", 16'h0000, haltCfg);
    rd_key(1'b0);
    lock_wr(8'h01, 1'b0);
    print_verdict;
  end
endmodule // test_prk_lock_top
